// File: slowdown_defines.svh
`ifndef SLOWDOWN_DEFINES_SVH
`define SLOWDOWN_DEFINES_SVH

// Shortest pulse that the filter passes, in ns.
`define FILTER_REJECT_NS 150
// Clock period, in ns.
`define SYS_CLK_PERIOD_NS 5
// Cycles a level must hold before the filter passes it (rounded up).
`define FILTER_CYCLES \
    ((`FILTER_REJECT_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define FILTER_CNT_W 5
`define FILTER_CNT_MAX 5'h1e

// Encodings of the two response settings.
`define STOP_SELECT_FEED 1'b0
`define STOP_SELECT_STOP 1'b1

`endif

// File: slowdown_input_control.sv
`timescale 1ns/10ps
`include "slowdown_defines.svh"

// Behaviour
// R1: Enable off ignores the input; enable on applies the chosen response. The latch still sets while off, and latched slowdown persists.
// R2: Stop-select and latch-enable pick one of four responses.
// R3: Plain decelerate: ignore in constant moves, slow while active.
// R4: Plain decelerate: active at start runs low, speeds up when clear.
// R5: Latched decelerate: after activation stay at low start speed.
// R6: Latched decelerate: active at start never reaches high speed.
// R7: Non-latched stop: constant stops at once; high decelerates then stops.
// R8: Stop modes: active at start completes with no motion.
// R9: Stop by slowdown sets the stop error and raises the interrupt.
// R10: Latched stop: never reaccelerates once slowdown began.
// R11: Polarity 0 means active low, 1 means active high.
// R12: Latch clears at a start when the input is inactive.
// R13: Latch held clear while latching is disabled.
// R14: Filter 0 rejects pulses under 150 ns; 1 bypasses it.
// R15: Raw input and latch state are readable status bits.
// R16: Input is synchronised before polarity, filtering and latching.
module slowdown_input_control
    import slowdown_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slowdownInput,
    input wire logic slowdownEnable,
    input wire logic slowdownStopSelect,
    input wire logic slowdownLatchEnable,
    input wire logic slowdownPolarity,
    input wire logic inputFilterBypass,
    input wire logic startCmd,
    input wire logic startHighSpeed,
    input wire logic moving,
    input wire logic atLowStartSpeed,
    input wire logic errorClear,
    output logic decelRequest_q,
    output logic stopRequest_q,
    output logic startAbort_q,
    output logic slowdownStatus_q,
    output logic slowdownLatchStatus_q,
    output logic stopError_q,
    output logic interruptRequest_q
);
    logic syncLevel;
    logic filtLevel;
    logic active;
    logic latched;
    logic effective;
    logic noAccel_q;
    logic noAccel_d;
    logic decelRequest_d;
    logic stopRequest_d;
    logic stopEvent;
    logic startActive;
    response_t resp;
    move_kind_t kind_q;

    slowdown_sync_filter slowdown_sync_filter_i
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn(slowdownInput),
        .filterBypass(inputFilterBypass),
        .syncOut(syncLevel),
        .filtOut(filtLevel)
    );

    // Polarity 1 is active high, 0 active low.
    assign active = slowdownPolarity ? filtLevel : ~filtLevel; // R11

    slowdown_latch slowdown_latch_i
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .active(active),
        .latchEnable(slowdownLatchEnable),
        .startCmd(startCmd),
        .latched(latched)
    );

    always_comb
    begin
        case ({slowdownStopSelect, slowdownLatchEnable}) // R2
            2'b00: resp = RESP_DECEL;
            2'b01: resp = RESP_LATCH_DECEL;
            2'b10: resp = RESP_DECEL_STOP;
            2'b11: resp = RESP_LATCH_DECEL_STOP;
            default: resp = RESP_DECEL;
        endcase
    end

    // Latched modes act on the latch so a brief pulse still counts.
    assign effective = slowdownEnable &&
        (slowdownLatchEnable ? (active || latched) : active); // R1

    // A start with the input inactive clears the latch, so a start is
    // judged on the live input alone and an old latch cannot abort it.
    assign startActive = slowdownEnable && active; // R12

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            kind_q <= MOVE_CONSTANT;
        end
        else if (startCmd)
        begin
            kind_q <= startHighSpeed ? MOVE_HIGH_SPEED : MOVE_CONSTANT;
        end
    end

    // Once a latched mode has slowed the move, high speed stays barred.
    always_comb
    begin
        noAccel_d = noAccel_q;
        if (startCmd)
        begin
            noAccel_d = 1'b0;
        end
        else if (effective && slowdownLatchEnable && moving)
        begin
            noAccel_d = 1'b1; // R5
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            noAccel_q <= 1'b0;
        end
        else
        begin
            noAccel_q <= noAccel_d;
        end
    end

    always_comb
    begin
        decelRequest_d = 1'b0;
        stopRequest_d = 1'b0;
        if (moving && kind_q == MOVE_HIGH_SPEED)
        begin
            case (resp)
                RESP_DECEL:
                    decelRequest_d = effective; // R3
                RESP_LATCH_DECEL:
                    decelRequest_d = effective || noAccel_q; // R5
                RESP_DECEL_STOP:
                begin
                    decelRequest_d = effective; // R7
                    stopRequest_d = effective && atLowStartSpeed; // R7
                end
                RESP_LATCH_DECEL_STOP:
                begin
                    decelRequest_d = effective || noAccel_q; // R10
                    stopRequest_d = (effective || noAccel_q) &&
                        atLowStartSpeed; // R10
                end
                default:
                    decelRequest_d = 1'b0;
            endcase
        end
        else if (moving && slowdownStopSelect == `STOP_SELECT_STOP)
        begin
            stopRequest_d = effective; // R7
        end
    end

    // A start with the input active holds speed low from the first cycle.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            decelRequest_q <= 1'b0;
            stopRequest_q <= 1'b0;
        end
        else
        begin
            decelRequest_q <= decelRequest_d ||
                (startCmd && startHighSpeed && startActive); // R4 R6
            stopRequest_q <= stopRequest_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            startAbort_q <= 1'b0;
        end
        else
        begin
            startAbort_q <= startCmd && startActive &&
                slowdownStopSelect == `STOP_SELECT_STOP; // R8
        end
    end

    assign stopEvent = stopRequest_d ||
        (startCmd && startActive && slowdownStopSelect == `STOP_SELECT_STOP);

    // The error set wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stopError_q <= 1'b0;
            interruptRequest_q <= 1'b0;
        end
        else if (stopEvent)
        begin
            stopError_q <= 1'b1; // R9
            interruptRequest_q <= 1'b1; // R9
        end
        else if (errorClear)
        begin
            stopError_q <= 1'b0;
            interruptRequest_q <= 1'b0;
        end
    end

    // Raw status reports the synchronised pin with polarity applied, before the filter.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            slowdownStatus_q <= 1'b0;
            slowdownLatchStatus_q <= 1'b0;
        end
        else
        begin
            slowdownStatus_q <= slowdownPolarity ? syncLevel : ~syncLevel; // R15
            slowdownLatchStatus_q <= latched; // R15
        end
    end

    AST_DISABLED_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        !slowdownEnable |=> !startAbort_q && !stopRequest_q) // R1
        else $error("slowdown acted while disabled");
    AST_PLAIN_DECEL: assert property (@(posedge sys_clk) disable iff (rst)
        (resp == RESP_DECEL && moving && kind_q == MOVE_HIGH_SPEED &&
        !startCmd) |=> decelRequest_q == $past(effective)) // R3
        else $error("plain decelerate did not follow input");
    AST_CONST_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        (!slowdownStopSelect && kind_q == MOVE_CONSTANT && !startCmd)
        |=> !decelRequest_q && !stopRequest_q) // R3
        else $error("constant move disturbed in decelerate mode");
    AST_START_LOW: assert property (@(posedge sys_clk) disable iff (rst)
        (startCmd && startHighSpeed && startActive) |=> decelRequest_q) // R4
        else $error("active start did not run low");
    AST_LATCH_STAYS: assert property (@(posedge sys_clk) disable iff (rst)
        (noAccel_q && resp == RESP_LATCH_DECEL && moving &&
        kind_q == MOVE_HIGH_SPEED && !startCmd) |=> decelRequest_q) // R5
        else $error("latched decelerate reaccelerated");
    AST_STOP_START: assert property (@(posedge sys_clk) disable iff (rst)
        (startCmd && startActive && slowdownStopSelect) |=>
        startAbort_q ##0 stopError_q) // R8
        else $error("active start in stop mode not aborted");
    AST_ERROR_SET: assert property (@(posedge sys_clk) disable iff (rst)
        stopRequest_q |-> stopError_q && interruptRequest_q) // R9
        else $error("stop without error flag");
    AST_CONST_STOP: assert property (@(posedge sys_clk) disable iff (rst)
        (moving && kind_q == MOVE_CONSTANT && slowdownStopSelect &&
        effective && !startCmd) |=> stopRequest_q) // R7
        else $error("constant move not stopped");
    AST_POLARITY: assert property (@(posedge sys_clk) disable iff (rst) // R11
        slowdownStatus_q == ($past(slowdownPolarity) ~^ $past(syncLevel)))
        else $error("raw status polarity wrong");
    AST_ABORT_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
        startAbort_q |-> $past(startCmd)) // R8
        else $error("abort without a start command");
    AST_ERROR_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
        (stopError_q && !errorClear) |=> stopError_q) // R9
        else $error("stop error dropped without a clear");
    AST_IRQ_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
        interruptRequest_q == stopError_q) // R9
        else $error("interrupt request differs from stop error");
    AST_LATCH_STATUS: assert property (@(posedge sys_clk) disable iff (rst)
        slowdownLatchStatus_q == $past(latched)) // R15
        else $error("latch status does not follow the latch");
    AST_LSTOP_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        (noAccel_q && resp == RESP_LATCH_DECEL_STOP && moving &&
        kind_q == MOVE_HIGH_SPEED && !startCmd) |=> decelRequest_q) // R10
        else $error("latched stop reaccelerated");
    AST_STOP_AT_LOW: assert property (@(posedge sys_clk) disable iff (rst)
        (resp == RESP_DECEL_STOP && moving && kind_q == MOVE_HIGH_SPEED &&
        effective && atLowStartSpeed) |=> stopRequest_q) // R7
        else $error("high speed move not stopped at low speed");
    AST_REACCEL: assert property (@(posedge sys_clk) disable iff (rst)
        (resp == RESP_DECEL_STOP && moving && kind_q == MOVE_HIGH_SPEED &&
        !effective && !startCmd) |=> !decelRequest_q) // R7
        else $error("stop mode did not reaccelerate");
    AST_FEED_NO_ABORT: assert property (@(posedge sys_clk) disable iff (rst)
        (startCmd && !slowdownStopSelect) |=> !startAbort_q) // R2
        else $error("abort in a feeding response");
    AST_START_CLEARS: assert property (@(posedge sys_clk) disable iff (rst)
        startCmd |=> !noAccel_q) // R5
        else $error("acceleration bar survived a start");
    AST_OFF_NO_DECEL: assert property (@(posedge sys_clk) disable iff (rst)
        (!slowdownEnable && !noAccel_q) |=> !decelRequest_q) // R1
        else $error("slowdown decelerated while disabled");
    AST_STOP_MOVING: assert property (@(posedge sys_clk) disable iff (rst)
        !moving |=> !stopRequest_q) // R7
        else $error("stop requested with no motion");
    AST_IDLE_NO_DECEL: assert property (@(posedge sys_clk) disable iff (rst)
        (!moving && !startCmd) |=> !decelRequest_q) // R3
        else $error("decelerate requested with no motion");

    COV_ABORT: cover property (@(posedge sys_clk) startAbort_q);
    COV_DECEL: cover property (@(posedge sys_clk)
        decelRequest_q ##1 !decelRequest_q);
    COV_STOP: cover property (@(posedge sys_clk) stopRequest_q);
    COV_LATCH: cover property (@(posedge sys_clk) slowdownLatchStatus_q);
    COV_ERROR: cover property (@(posedge sys_clk)
        stopError_q ##1 !stopError_q);
endmodule

// File: slowdown_input_control_test.sv
`timescale 1ns/10ps

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            errorCnt++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module slowdown_input_control_test;
    import slowdown_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sensorActive = 1'b0;
    logic slowdownInput;
    logic enable = 1'b1;
    logic stopSel = 1'b0;
    logic latchEn = 1'b0;
    logic pol = 1'b1;
    logic bypass = 1'b1;
    logic startCmd = 1'b0;
    logic startHs = 1'b0;
    logic moving = 1'b0;
    logic atLow = 1'b0;
    logic errClr = 1'b0;
    logic decel, stop, abort, status, latchSt, stopErr, irq;
    int errorCnt = 0;
    int comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    slowdown_sensor_model slowdown_sensor_model_i
    (
        .active(sensorActive),
        .polarity(pol),
        .pin(slowdownInput)
    );

    slowdown_input_control slowdown_input_control_i
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .slowdownInput(slowdownInput),
        .slowdownEnable(enable),
        .slowdownStopSelect(stopSel),
        .slowdownLatchEnable(latchEn),
        .slowdownPolarity(pol),
        .inputFilterBypass(bypass),
        .startCmd(startCmd),
        .startHighSpeed(startHs),
        .moving(moving),
        .atLowStartSpeed(atLow),
        .errorClear(errClr),
        .decelRequest_q(decel),
        .stopRequest_q(stop),
        .startAbort_q(abort),
        .slowdownStatus_q(status),
        .slowdownLatchStatus_q(latchSt),
        .stopError_q(stopErr),
        .interruptRequest_q(irq)
    );

    task automatic finalReport;
        if (errorCnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Every stimulus change lands 1 ns after a rising edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic sense(input logic a, input int n);
        sensorActive = a;
        cyc(n);
    endtask

    task automatic setMode(input logic s, input logic l);
        stopSel = s;
        latchEn = l;
        moving = 1'b0;
        atLow = 1'b0;
        cyc(2);
    endtask

    task automatic startMove(input logic hs);
        startHs = hs;
        startCmd = 1'b1;
        cyc(1);
        startCmd = 1'b0;
        moving = 1'b1;
    endtask

    task automatic clearErr;
        errClr = 1'b1;
        cyc(1);
        errClr = 1'b0;
        cyc(1);
    endtask

    // A hang ends the run with a counted mismatch.
    initial
    begin
        #200000;
        errorCnt++;
        finalReport();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        `CHK({decel, stop, abort, status, latchSt, stopErr, irq}, 7'h00)
        for (int p = 0; p < 2; p++)
        begin
            pol = p[0];
            sense(1'b1, 6);
            `CHK(status, 1'b1)
            sense(1'b0, 6);
            `CHK(status, 1'b0)
        end
        pol = 1'b1;
        startMove(1'b0);
        sense(1'b1, 6);
        `CHK(decel, 1'b0)
        sense(1'b0, 6);
        startMove(1'b1);
        sense(1'b1, 6);
        `CHK(decel, 1'b1)
        sense(1'b0, 6);
        `CHK(decel, 1'b0)
        sense(1'b1, 6);
        startMove(1'b1);
        cyc(3);
        `CHK(decel, 1'b1)
        sense(1'b0, 6);
        `CHK(decel, 1'b0)
        // A 145 ns pulse sits just under the rejection limit.
        bypass = 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            sensorActive = (i < 29);
            cyc(1);
            `CHK(decel, 1'b0)
        end
        sense(1'b1, 40);
        `CHK(decel, 1'b1)
        sense(1'b0, 40);
        bypass = 1'b1;
        setMode(1'b0, 1'b1);
        startMove(1'b1);
        sense(1'b1, 6);
        `CHK(decel, 1'b1)
        sense(1'b0, 6);
        `CHK(decel, 1'b1)
        `CHK(latchSt, 1'b1)
        startMove(1'b1);
        cyc(2);
        `CHK(latchSt, 1'b0)
        sense(1'b1, 6);
        startMove(1'b1);
        sense(1'b0, 6);
        `CHK(latchSt, 1'b1)
        `CHK(decel, 1'b1)
        latchEn = 1'b0;
        cyc(3);
        `CHK(latchSt, 1'b0)
        setMode(1'b1, 1'b0);
        startMove(1'b0);
        sense(1'b1, 6);
        `CHK(stop, 1'b1)
        `CHK({stopErr, irq}, 2'b11)
        sense(1'b0, 3);
        clearErr();
        `CHK({stopErr, irq}, 2'b00)
        startMove(1'b1);
        sense(1'b1, 6);
        `CHK({decel, stop}, 2'b10)
        sense(1'b0, 6);
        `CHK(decel, 1'b0)
        sense(1'b1, 6);
        atLow = 1'b1;
        cyc(3);
        `CHK(stop, 1'b1)
        clearErr();
        for (int l = 0; l < 2; l++)
        begin
            setMode(1'b1, l[0]);
            startMove(l[0]);
            `CHK(abort, 1'b1)
            cyc(1);
            `CHK(abort, 1'b0)
        end
        setMode(1'b1, 1'b1);
        sense(1'b0, 6);
        startMove(1'b1);
        sense(1'b1, 6);
        `CHK(decel, 1'b1)
        sense(1'b0, 6);
        `CHK(decel, 1'b1)
        atLow = 1'b1;
        for (int i = 0; i < 10 && stop !== 1'b1; i++)
            cyc(1);
        `CHK(stop, 1'b1)
        moving = 1'b0;
        clearErr();
        enable = 1'b0;
        setMode(1'b1, 1'b0);
        startMove(1'b0);
        `CHK(abort, 1'b0)
        sense(1'b1, 6);
        `CHK({stop, stopErr}, 2'b00)
        finalReport();
    end
endmodule

// File: slowdown_latch.sv
`timescale 1ns/10ps
`include "slowdown_defines.svh"

module slowdown_latch
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic active,
    input wire logic latchEnable,
    input wire logic startCmd,
    output logic latched
);
    logic latch_q;

    // A set on the start edge wins over the clear so an event is not lost.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            latch_q <= 1'b0;
        end
        else if (!latchEnable)
        begin
            latch_q <= 1'b0; // R13
        end
        else if (active)
        begin
            latch_q <= 1'b1;
        end
        else if (startCmd)
        begin
            latch_q <= 1'b0; // R12
        end
    end

    assign latched = latch_q;

    AST_LATCH_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(latchEnable) |-> !latch_q) // R13
        else $error("latch set while latching disabled");
    AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        (latchEnable && active) ##1 latchEnable |-> latch_q) // R12
        else $error("latch not set by an active input");
endmodule

// File: slowdown_pkg.sv
package slowdown_pkg;

    typedef enum logic [1:0]
    {
        MOVE_CONSTANT,
        MOVE_HIGH_SPEED
    } move_kind_t;

    typedef enum logic [1:0]
    {
        RESP_DECEL,
        RESP_LATCH_DECEL,
        RESP_DECEL_STOP,
        RESP_LATCH_DECEL_STOP
    } response_t;

endpackage

// File: slowdown_sensor_model.sv
`timescale 1ns/10ps

module slowdown_sensor_model
(
    input wire logic active,
    input wire logic polarity,
    output logic pin
);
    // The switch is wired to match the polarity setting, so an active
    // sensor always reads as active. Both wirings are exercised this way.
    assign pin = active ? polarity : ~polarity;
endmodule

// File: slowdown_sync_filter.sv
`timescale 1ns/10ps
`include "slowdown_defines.svh"

module slowdown_sync_filter
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pinIn,
    input wire logic filterBypass,
    output logic syncOut,
    output logic filtOut
);
    logic meta_q;
    logic sync_q;
    logic filt_q;
    logic [`FILTER_CNT_W-1:0] cnt_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= pinIn; // R16
            sync_q <= meta_q; // R16
        end
    end

    // A new level must stay for the full reject time before it passes.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            filt_q <= 1'b0;
        end
        else if (sync_q == filt_q)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q >= `FILTER_CNT_MAX - 5'h01)
        begin
            cnt_q <= '0;
            filt_q <= sync_q; // R14
        end
        else
        begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    assign syncOut = sync_q;
    assign filtOut = filterBypass ? sync_q : filt_q; // R14

    AST_FILTER_REJECTS: assert property (@(posedge sys_clk) disable iff (rst)
        (!filterBypass && $changed(filt_q)) |->
        $past(sync_q, 1) == sync_q) // R14
        else $error("filter passed a level that did not hold");
endmodule
